/* logic/fgdio_cfg.svh */
// Register offsets, reset values and timing counts of the digital I/O port
`ifndef FGDIO_CFG_SVH
`define FGDIO_CFG_SVH
`define FGDIO_ADDR_W 8
`define FGDIO_TYPE_OFF 8'h00
`define FGDIO_STATE_OFF 8'h04
`define FGDIO_STROBE_OFF 8'h08
`define FGDIO_WAIT_OFF 8'h0c
`define FGDIO_SWITCH_OFF 8'h10
`define FGDIO_IRQ_STAT_OFF 8'h14
`define FGDIO_IRQ_MASK_OFF 8'h18
`define FGDIO_PERIOD_OFF 8'h20
`define FGDIO_TYPE_RESET 8'h00
`define FGDIO_OUT_TYPES 8'hff
`define FGDIO_WAIT_EVERY_BIT 8
`define FGDIO_WAIT_BUSY_BIT 9
`define FGDIO_WAIT_DONE_BIT 10
`define FGDIO_IRQ_RESET 5'h00
`define FGDIO_CLK_NS 50
`define FGDIO_TICK_NS 1000
`define FGDIO_TICK_CYCLES (`FGDIO_TICK_NS / `FGDIO_CLK_NS)
`endif

/* logic/fgdio_pkg.sv */
// Types shared by the digital I/O port modules
package fgdio_pkg;
  typedef enum logic [1:0] {
    level_input_type = 2'h0,
    latch_on_rise_type = 2'h1,
    latch_on_fall_type = 2'h2,
    fixed_output_type = 2'h3
  } fgdio_io_kind_type;

  typedef enum logic [2:0] {
    wait_idle = 3'b001,
    wait_armed = 3'b010,
    wait_done = 3'b100
  } fgdio_wait_state_type;
endpackage : fgdio_pkg

/* logic/fgdio_in_line.sv */
// One input line: level follower or rising/falling edge latch
`timescale 1ns/1ps
module fgdio_in_line
  import fgdio_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and control
  input wire logic pin,
  input wire fgdio_io_kind_type kind,
  input wire logic clear,
  // Result
  output logic state,
  output logic edge_hit
);
  logic pin_q;
  logic armed;
  logic latched;

  // No edge is judged before the first sampled pin level
  wire rise_w = armed & pin & ~pin_q;
  wire fall_w = armed & ~pin & pin_q;
  wire hit_w = (kind == latch_on_rise_type) ? rise_w :
               (kind == latch_on_fall_type) ? fall_w : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      armed <= 1'b0;
      latched <= 1'b0;
    end else begin
      pin_q <= pin;
      armed <= 1'b1;
      latched <= hit_w | (latched & ~clear);
    end
  end

  assign state = (kind == level_input_type) ? pin : latched;
  assign edge_hit = hit_w;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_latch_a: assert property (
    armed && kind == latch_on_rise_type && !pin_q && pin |=> latched)
    else $error("rising edge not latched");
  fall_latch_a: assert property (
    armed && kind == latch_on_fall_type && pin_q && !pin |=> latched)
    else $error("falling edge not latched");
  level_follow_a: assert property (
    kind == level_input_type |-> state == pin)
    else $error("level input does not follow pin");
  latch_hold_a: assert property (
    latched && !clear |=> latched)
    else $error("latched state lost without clear");
endmodule : fgdio_in_line

/* logic/fgdio_strobe.sv */
// One output line: pulse of programmed length counted in microsecond ticks
`timescale 1ns/1ps
module fgdio_strobe #(
  parameter int PERIOD_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic [PERIOD_W-1:0] period,
  // Pin
  output logic pulse
);
  localparam logic [PERIOD_W-1:0] ONE_C = PERIOD_W'(1);
  logic [PERIOD_W-1:0] remain;

  wire load_w = start & (period != '0);
  wire last_w = pulse & tick & (remain == ONE_C);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= '0;
      pulse <= 1'b0;
    end else if (load_w) begin
      remain <= period;
      pulse <= 1'b1;
    end else if (pulse && tick) begin
      remain <= remain - ONE_C;
      pulse <= ~last_w;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_start_a: assert property (
    load_w |=> pulse && remain == $past(period))
    else $error("strobe did not start with programmed length");
  strobe_end_a: assert property (
    last_w && !start |=> !pulse && remain == '0)
    else $error("strobe did not end after its period");
  strobe_hold_a: assert property (
    pulse && !tick && !start |=> pulse && $stable(remain))
    else $error("strobe changed between ticks");
endmodule : fgdio_strobe

/* logic/fgdio_top.sv */
// Digital I/O port: four input lines, four strobe outputs, event wait, APB registers
//
// Behaviour
// - Lines 0 to 3 are inputs only: level, rising latch or falling latch.
// - Lines 4 to 7 are outputs; their type always reads back as output.
// - Rising-latch line records 1 when the pin goes low to high.
// - Falling-latch line records 1 when the pin goes high to low.
// - Level line reports the current pin value, without latching.
// - Each output line has its own strobe period, readable per line.
// - Completed wait records highest satisfying line; reads zero until then.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "fgdio_cfg.svh"
module fgdio_top
  import fgdio_pkg::*;
#(
  parameter int PERIOD_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FGDIO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  // Interrupt
  output logic irq
);
  localparam int TICK_W = $clog2(`FGDIO_TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`FGDIO_TICK_CYCLES - 1);

  // Index of the highest set bit of a line set
  function automatic logic [2:0] highest_line(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : highest_line

  // APB decode
  wire setup_w = psel & ~penable;
  wire access_w = psel & penable;
  wire wr_w = access_w & pwrite;
  wire rd_setup_w = setup_w & ~pwrite;
  wire rd_access_w = access_w & ~pwrite;

  wire hit_type_w = paddr == `FGDIO_TYPE_OFF;
  wire hit_state_w = paddr == `FGDIO_STATE_OFF;
  wire hit_strobe_w = paddr == `FGDIO_STROBE_OFF;
  wire hit_wait_w = paddr == `FGDIO_WAIT_OFF;
  wire hit_switch_w = paddr == `FGDIO_SWITCH_OFF;
  wire hit_stat_w = paddr == `FGDIO_IRQ_STAT_OFF;
  wire hit_mask_w = paddr == `FGDIO_IRQ_MASK_OFF;
  wire [3:0] hit_period_w;
  wire hit_any_w = hit_type_w | hit_state_w | hit_strobe_w | hit_wait_w | hit_switch_w |
                   hit_stat_w | hit_mask_w | (|hit_period_w);

  wire wr_type_w = wr_w & hit_type_w;
  wire wr_state_w = wr_w & hit_state_w;
  wire wr_strobe_w = wr_w & hit_strobe_w;
  wire wr_wait_w = wr_w & hit_wait_w;
  wire wr_mask_w = wr_w & hit_mask_w;
  wire rd_stat_w = rd_access_w & hit_stat_w;

  // Line state
  fgdio_io_kind_type kind_q [4];
  logic [PERIOD_W-1:0] period_q [4];
  wire [3:0] type_change_w;
  wire [3:0] clear_w;
  wire [3:0] in_state_w;
  wire [3:0] edge_hit_w;
  wire [3:0] strobe_go_w;
  wire [7:0] kind_rb_w;

  // Microsecond tick for strobe timing
  logic [TICK_W-1:0] tick_cnt;
  wire tick_w = tick_cnt == TICK_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_w ? '0 : tick_cnt + TICK_W'(1);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_line
      wire [1:0] req_w = pwdata[2*g+1:2*g];
      // Output type is refused on an input line
      assign type_change_w[g] = wr_type_w && req_w != 2'(fixed_output_type) &&
                                req_w != 2'(kind_q[g]);
      assign clear_w[g] = (wr_state_w & pwdata[g]) | type_change_w[g];
      assign hit_period_w[g] = paddr == `FGDIO_ADDR_W'(`FGDIO_PERIOD_OFF + 4 * g);
      assign strobe_go_w[g] = wr_strobe_w & pwdata[g];
      assign kind_rb_w[2*g+1:2*g] = 2'(kind_q[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          kind_q[g] <= level_input_type;
          period_q[g] <= '0;
        end else begin
          if (type_change_w[g]) begin
            kind_q[g] <= fgdio_io_kind_type'(req_w);
          end
          if (wr_w && hit_period_w[g]) begin
            period_q[g] <= pwdata[PERIOD_W-1:0];
          end
        end
      end

      fgdio_in_line u_in (
        .pclk(pclk),
        .presetn(presetn),
        .pin(line_in[g]),
        .kind(kind_q[g]),
        .clear(clear_w[g]),
        .state(in_state_w[g]),
        .edge_hit(edge_hit_w[g])
      );

      fgdio_strobe #(
        .PERIOD_W(PERIOD_W)
      ) u_out (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_w),
        .start(strobe_go_w[g]),
        .period(period_q[g]),
        .pulse(line_out[g])
      );
    end
  endgenerate

  // Event wait
  fgdio_wait_state_type wait_state;
  fgdio_wait_state_type next_wait_state;
  logic [3:0] wait_mask;
  logic wait_every;
  logic [2:0] switch_line;
  logic [2:0] next_switch_line;

  wire [3:0] seen_w = in_state_w & wait_mask;
  wire any_ok_w = |seen_w;
  wire every_ok_w = seen_w == wait_mask;
  wire wait_met_w = (wait_state == wait_armed) && !wr_wait_w &&
                    (wait_every ? every_ok_w : any_ok_w);
  wire [2:0] any_line_w = highest_line(seen_w);
  wire [2:0] every_line_w = highest_line(wait_mask);

  always_comb begin
    next_wait_state = wait_state;
    next_switch_line = switch_line;
    case (wait_state)
      wait_idle, wait_done: begin
        if (wr_wait_w && pwdata[3:0] != 4'h0) begin
          next_wait_state = wait_armed;
          next_switch_line = 3'h0;
        end
      end
      wait_armed: begin
        if (wr_wait_w) begin
          next_wait_state = (pwdata[3:0] != 4'h0) ? wait_armed : wait_idle;
        end else if (wait_met_w) begin
          next_wait_state = wait_done;
          next_switch_line = wait_every ? every_line_w : any_line_w;
        end
      end
      default: begin
        next_wait_state = wait_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_state <= wait_idle;
      switch_line <= 3'h0;
      wait_mask <= 4'h0;
      wait_every <= 1'b0;
    end else begin
      wait_state <= next_wait_state;
      switch_line <= next_switch_line;
      if (wr_wait_w) begin
        wait_mask <= pwdata[3:0];
        wait_every <= pwdata[`FGDIO_WAIT_EVERY_BIT];
      end
    end
  end

  // Interrupt status: bit 0 wait done, bits 4:1 input edges
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  wire [4:0] irq_set_w = {edge_hit_w, wait_met_w};
  wire [4:0] irq_clr_w = rd_stat_w ? prdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= `FGDIO_IRQ_RESET;
      irq_mask <= `FGDIO_IRQ_RESET;
    end else begin
      // A new event wins over the read that clears it
      irq_stat <= (irq_stat & ~irq_clr_w) | irq_set_w;
      if (wr_mask_w) begin
        irq_mask <= pwdata[4:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data, captured in the setup phase
  wire [31:0] wait_rb_w = {21'h0, wait_state == wait_done, wait_state == wait_armed,
                           wait_every, 4'h0, wait_mask};
  wire [31:0] rdata_w =
    hit_type_w ? {16'h0, `FGDIO_OUT_TYPES, kind_rb_w} :
    hit_state_w ? {24'h0, line_out, in_state_w} :
    hit_wait_w ? wait_rb_w :
    hit_switch_w ? {29'h0, switch_line} :
    hit_stat_w ? {27'h0, irq_stat} :
    hit_mask_w ? {27'h0, irq_mask} :
    hit_period_w[0] ? 32'(period_q[0]) :
    hit_period_w[1] ? 32'(period_q[1]) :
    hit_period_w[2] ? 32'(period_q[2]) :
    hit_period_w[3] ? 32'(period_q[3]) : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup_w) begin
      prdata <= rdata_w;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access_w & ~hit_any_w;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  type_readback_a: assert property (
    rd_setup_w && hit_type_w |=> prdata[15:8] == `FGDIO_OUT_TYPES)
    else $error("output line type not reported as output");
  input_kind_a: assert property (
    wr_type_w && pwdata[1:0] == 2'(fixed_output_type) |=> $stable(kind_q[0]))
    else $error("input line accepted output type");
  input_never_out_a: assert property (
    kind_q[3] != fixed_output_type)
    else $error("input line holds output type");
  period_store_a: assert property (
    wr_w && hit_period_w[2] |=> period_q[2] == $past(pwdata[PERIOD_W-1:0]))
    else $error("strobe period not stored");
  switch_zero_a: assert property (
    wait_state != wait_done |-> switch_line == 3'h0)
    else $error("switch value not zero before wait completes");
  switch_any_a: assert property (
    wait_met_w && !wait_every |=> wait_state == wait_done &&
      switch_line == $past(any_line_w))
    else $error("any-line wait recorded wrong line");
  switch_every_a: assert property (
    wait_met_w && wait_every |=> switch_line == $past(every_line_w))
    else $error("every-line wait recorded wrong line");
  strobe_cmd_a: assert property (
    strobe_go_w[1] && period_q[1] > PERIOD_W'(1) |=> line_out[1] ##1 line_out[1])
    else $error("commanded strobe did not pulse");
  reconfig_clear_a: assert property (
    type_change_w[0] && !edge_hit_w[0] && kind_q[0] != level_input_type
      |=> kind_q[0] == level_input_type || !in_state_w[0] || $rose(line_in[0])
      || $fell(line_in[0]))
    else $error("reconfiguration did not clear latch");

  // Register bus and interrupt status
  period_rb_a: assert property (
    rd_setup_w && hit_period_w[0] |=> prdata == 32'($past(period_q[0])))
    else $error("strobe period read back wrong");
  bad_write_a: assert property (
    wr_w && !hit_any_w |=> $stable(kind_q[1]) && $stable(wait_mask))
    else $error("write to unmapped address changed state");
  wait_irq_a: assert property (
    wait_met_w |=> irq_stat[0])
    else $error("completed wait not flagged");
  done_sticky_a: assert property (
    irq_stat[0] && !(rd_stat_w && prdata[0]) |=> irq_stat[0])
    else $error("wait done flag lost without read");
  edge_irq_a: assert property (
    edge_hit_w[3] |=> irq_stat[4])
    else $error("edge on line 3 not flagged");
  edge_clr_a: assert property (
    rd_stat_w && prdata[4] && !edge_hit_w[3] |=> !irq_stat[4])
    else $error("edge flag not cleared by read");

  // Input lines
  rise_state_a: assert property (
    edge_hit_w[1] && kind_q[1] == latch_on_rise_type && !type_change_w[1]
      |=> in_state_w[1])
    else $error("rising edge not reported in line state");
  fall_state_a: assert property (
    edge_hit_w[2] && kind_q[2] == latch_on_fall_type && !type_change_w[2]
      |=> in_state_w[2])
    else $error("falling edge not reported in line state");
  level_state_a: assert property (
    kind_q[0] == level_input_type |-> in_state_w[0] == line_in[0])
    else $error("level line state differs from pin");
  state_clear_a: assert property (
    wr_state_w && pwdata[1] && !edge_hit_w[1] && kind_q[1] != level_input_type
      |=> !in_state_w[1])
    else $error("latch not cleared by software");

  // Event wait
  arm_clear_a: assert property (
    wr_wait_w && pwdata[3:0] != 4'h0
      |=> wait_state == wait_armed && switch_line == 3'h0)
    else $error("new wait not armed with switch cleared");
  wait_cancel_a: assert property (
    wait_state == wait_armed && wr_wait_w && pwdata[3:0] == 4'h0
      |=> wait_state == wait_idle && switch_line == 3'h0)
    else $error("cancelled wait not idle");
  switch_hold_a: assert property (
    wait_state == wait_done && !wr_wait_w |=> $stable(switch_line))
    else $error("switch value changed after completion");

  // Strobes
  tick_gap_a: assert property (
    tick_w |=> !tick_w [*8])
    else $error("strobe tick too frequent");
  strobe_out3_a: assert property (
    strobe_go_w[3] && period_q[3] != '0 |=> line_out[3])
    else $error("strobe on line 7 did not start");

  rise_seen_c: cover property (kind_q[0] == latch_on_rise_type && edge_hit_w[0]);
  any_done_c: cover property (wait_met_w && !wait_every);
  every_done_c: cover property (wait_met_w && wait_every);
  strobe_end_c: cover property ($fell(line_out[3]));
  cancel_c: cover property (wait_state == wait_armed && wr_wait_w && pwdata[3:0] == 4'h0);
endmodule : fgdio_top

/* dv/fgdio_pins_model.sv */
// Pin-side equipment model: switch levels into the port and strobe timing out of it
`timescale 1ns/1ps
module fgdio_pins_model (
  // Clock
  input wire logic pclk,
  // Levels requested by the bench
  input wire logic [3:0] pin_drive,
  // Pins
  input wire logic [3:0] line_out,
  output logic [3:0] line_in
);
  int cnt [4] = '{default: 0};
  int width [4] = '{default: 0};

  // Switches change level right after a clock edge, never mid-cycle
  always @(posedge pclk) begin
    line_in <= pin_drive;
    for (int k = 0; k < 4; k++) begin
      if (line_out[k] === 1'b1) begin
        cnt[k] <= cnt[k] + 1;
      end else if (cnt[k] != 0) begin
        width[k] <= cnt[k];
        cnt[k] <= 0;
      end
    end
  end
endmodule : fgdio_pins_model

/* dv/frame_grabber_digital_io_tb.sv */
// Self-checking testbench of the digital I/O port over APB
`timescale 1ns/1ps
`include "fgdio_cfg.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module frame_grabber_digital_io_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`FGDIO_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin_drive = 4'h0;
  logic [3:0] line_in;
  logic [3:0] line_out;
  logic irq;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int n_tests = 0;
  int i;

  always #25 pclk = ~pclk;

  fgdio_top #(.PERIOD_W(24)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_out(line_out), .irq(irq)
  );

  fgdio_pins_model pins (
    .pclk(pclk), .pin_drive(pin_drive), .line_out(line_out), .line_in(line_in)
  );

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    `CHK(rd, exp)
  endtask : rdchk

  // Pin levels need a few edges to pass the sampler and edge detector
  task automatic setpins(input logic [3:0] v);
    @(posedge pclk);
    pin_drive <= v;
    repeat (3) @(posedge pclk);
  endtask : setpins

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`FGDIO_TYPE_OFF, 32'h0000ff00);
    rdchk(`FGDIO_SWITCH_OFF, 32'h0);
    wr(`FGDIO_TYPE_OFF, 32'hffffffff);
    rdchk(`FGDIO_TYPE_OFF, 32'h0000ff00);
    // Line 0 level, 1 rise, 2 fall, 3 rise
    wr(`FGDIO_TYPE_OFF, 32'h00000064);
    rdchk(`FGDIO_TYPE_OFF, 32'h0000ff64);
    setpins(4'h1);
    rdchk(`FGDIO_STATE_OFF, 32'h1);
    setpins(4'h6);
    rdchk(`FGDIO_STATE_OFF, 32'h2);
    setpins(4'h0);
    rdchk(`FGDIO_STATE_OFF, 32'h6);
    wr(`FGDIO_STATE_OFF, 32'h2);
    rdchk(`FGDIO_STATE_OFF, 32'h4);
    rdchk(`FGDIO_IRQ_STAT_OFF, 32'hc);
    rdchk(`FGDIO_IRQ_STAT_OFF, 32'h0);
    wr(`FGDIO_IRQ_MASK_OFF, 32'h10);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    setpins(4'h8);
    `CHK(irq, 1'b1)
    rdchk(`FGDIO_IRQ_STAT_OFF, 32'h10);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    // Wait for every line of mask 1,3; line 1 is not latched yet
    wr(`FGDIO_WAIT_OFF, 32'h10a);
    rdchk(`FGDIO_WAIT_OFF, 32'h30a);
    rdchk(`FGDIO_SWITCH_OFF, 32'h0);
    setpins(4'ha);
    rdchk(`FGDIO_SWITCH_OFF, 32'h3);
    apb(1'b0, `FGDIO_WAIT_OFF, 32'h0);
    `CHK(rd & 32'h600, 32'h400)
    `CHK(irq, 1'b0)
    wr(`FGDIO_WAIT_OFF, 32'h6);
    rdchk(`FGDIO_SWITCH_OFF, 32'h2);
    // Arm a wait that cannot complete, then cancel it
    wr(`FGDIO_WAIT_OFF, 32'h1);
    rdchk(`FGDIO_WAIT_OFF, 32'h201);
    rdchk(`FGDIO_SWITCH_OFF, 32'h0);
    wr(`FGDIO_WAIT_OFF, 32'h0);
    rdchk(`FGDIO_WAIT_OFF, 32'h0);
    // Line 2 back to level input drops its latch
    wr(`FGDIO_TYPE_OFF, 32'h00000044);
    rdchk(`FGDIO_STATE_OFF, 32'ha);
    apb(1'b1, 8'h1c, 32'hffffffff);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    for (int k = 0; k < 4; k++) wr(`FGDIO_PERIOD_OFF + 8'(4 * k), 32'(k + 2));
    for (int k = 0; k < 4; k++) rdchk(`FGDIO_PERIOD_OFF + 8'(4 * k), 32'(k + 2));
    wr(`FGDIO_STROBE_OFF, 32'hf);
    repeat (2) @(posedge pclk);
    `CHK(line_out, 4'hf)
    rdchk(`FGDIO_STATE_OFF, 32'hfa);
    for (i = 0; i < 300 && line_out !== 4'h0; i++) @(posedge pclk);
    `CHK(line_out, 4'h0)
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      `CHK(pins.width[k] > (k + 1) * 20 && pins.width[k] <= (k + 2) * 20, 1'b1)
    end
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end
endmodule : frame_grabber_digital_io_tb
